// File: rtl/wdt_count_core.sv
`timescale 1ns/1ps

module wdt_count_core (
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        rst_n_in,
    // control
    input  wire logic                        clear_in,
    input  wire logic                        tick_in,
    input  wire logic [4:0]                  ps_code_in,
    // state
    output logic      [wdt_pkg::COUNT_W-1:0] count_out,
    output logic                             timeout_out,
    output logic      [2:0]                  eighth_out
);

    logic [23:0]                  ratio;
    logic [wdt_pkg::COUNT_W-1:0] limit;
    logic [wdt_pkg::COUNT_W-1:0] shifted;
    logic [wdt_pkg::COUNT_W-1:0] count_r;
    logic                         timeout_r;

    // code 18 gives 2^23, whose limit is all ones
    always_comb begin
        ratio   = wdt_pkg::RATIO_MIN << ps_code_in;
        limit   = 23'(ratio - 24'h00_0001);
        shifted = count_r >> (ps_code_in + 5'd2);
    end

    // clear always wins over a tick
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= '0;
        end else if (clear_in) begin
            count_r <= '0;
        end else if (tick_in) begin
            count_r <= (count_r == limit) ? '0 : count_r + 23'd1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timeout_r <= 1'b0;
        end else begin
            timeout_r <= !clear_in && tick_in && (count_r == limit);
        end
    end

    assign count_out   = count_r;
    assign timeout_out = timeout_r;
    assign eighth_out  = shifted[2:0];

endmodule : wdt_count_core

// File: rtl/wdt_pkg.sv
package wdt_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CTRL0  = 4'h0;
    localparam logic [3:0] OFF_CTRL1  = 4'h1;
    localparam logic [3:0] OFF_PSL    = 4'h2;
    localparam logic [3:0] OFF_PSH    = 4'h3;
    localparam logic [3:0] OFF_TMR    = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h5;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL0_SEN_BIT  = 0;
    localparam int CTRL0_PS_LSB   = 1;
    localparam int CTRL1_WIN_LSB  = 0;
    localparam int CTRL1_CS_LSB   = 4;
    localparam int TMR_PRESCALE_COUNT_LSB  = 0;
    localparam int TMR_STATE_BIT  = 2;
    localparam int TMR_VALUE_LSB  = 3;
    localparam int STAT_TO_BIT    = 0;
    localparam int STAT_PD_BIT    = 1;
    localparam int STAT_CAUSE_BIT = 2;
    localparam int STAT_WV_BIT    = 3;

    // ------------------------------------------------------------
    // widths and codes
    // ------------------------------------------------------------
    localparam int COUNT_W = 23;
    localparam int PRESCALE_COUNT_W = 18;

    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_SW     = 2'h1;
    localparam logic [1:0] MODE_AWAKE  = 2'h2;
    localparam logic [1:0] MODE_ALWAYS = 2'h3;

    localparam logic [4:0] PS_UNLOCK   = 5'h1F;
    localparam logic [4:0] PS_DEFAULT  = 5'h0B;
    localparam logic [4:0] PS_MAX      = 5'h12;
    localparam logic [4:0] PS_MIN      = 5'h00;
    localparam logic [2:0] CS_UNLOCK   = 3'h7;
    localparam logic [2:0] CS_DEFAULT  = 3'h0;
    localparam logic [2:0] CS_MF       = 3'h1;
    localparam logic [2:0] WIN_UNLOCK  = 3'h7;
    localparam logic [2:0] WIN_FULL    = 3'h7;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [4:0] PS_RST     = 5'h00;
    localparam logic [2:0] CS_RST     = 3'h0;
    localparam logic [2:0] WIN_RST    = 3'h0;
    localparam logic       SEN_RST    = 1'b0;
    localparam logic       FLAG_N_RST = 1'b1;
    localparam logic [7:0] RDATA_RST  = 8'h00;
    // divide ratio of code zero, 1:32
    localparam logic [23:0] RATIO_MIN = 24'h00_0020;

endpackage : wdt_pkg

// File: rtl/wdt_top.sv
// Functional notes
// R1 - windowed mode: clear instruction works only after a read of control zero arms
// R2 - clear instruction while unarmed in windowed mode is a window violation
// R3 - counter cleared on sleep entry and again on sleep exit
// R4 - enabled in sleep: counting resumes after the entry clear
// R5 - counter held clear while the oscillator start-up timer runs
// R6 - time-out in sleep wakes the device instead of resetting it
// R7 - sleep time-out wake updates time-out, power-down and reset-cause flags
// R8 - held clear for mode 00, mode 01 with enable low, oscillator failure
// R9 - mode 10: cleared on sleep entry, and on exit from listed clocks
// R10 - oscillator divider changes leave the count untouched
// R11 - prescale code selects ratio 1:32 shifted left by the code
// R12 - prescale codes 10011 to 11111 act as 1:32
// R13 - prescale reset value 01011 if config is 11111, else the config value
// R14 - prescale field writable only when config prescale is all ones
// R15 - software enable bit 0 acts only in mode 01
// R16 - clock select 000 low-frequency source, 001 medium-frequency divided source
// R17 - clock select resets to 000 if config is 111, else config value
// R18 - clock select writable only when config clock select is 111
// R19 - window code opens (code+1) eighths at the end of the period
// R20 - window field resets to the config window value
// R21 - window field writable only when config window is 111
// R22 - 18-bit prescale count readable over read-only registers
// R23 - mode: 11 always, 10 awake only, 01 software, 00 off
// R24 - window violation resets the device and clears its active-low flag
// R25 - any write to either control register clears the counter
// R26 - awake and active: time-out without valid clear resets the device
// R27 - arm set by control zero read, cleared with counter; closed-window clear violates
`timescale 1ns/1ps

module wdt_top (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // register port
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // configuration word
    input  wire logic [1:0] mode_field_in,
    input  wire logic [4:0] config_prescale_field_in,
    input  wire logic [2:0] config_clock_select_field_in,
    input  wire logic [2:0] config_window_field_in,
    // processor core
    input  wire logic       clear_watchdog_in,
    input  wire logic       sleep_in,
    // oscillator and start-up
    input  wire logic       low_freq_tick_in,
    input  wire logic       medium_freq_tick_in,
    input  wire logic       ost_running_in,
    input  wire logic       osc_fail_in,
    input  wire logic       listed_clock_in,
    // reset, wake and arm state
    output logic            wdt_reset_out,
    output logic            wake_out,
    output logic            armed_out,
    // active-low status flags
    output logic            timeout_flag_n_out,
    output logic            power_down_flag_n_out,
    output logic            watchdog_reset_cause_flag_n_out,
    output logic            window_violation_flag_n_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        load_pending_r;
    logic [4:0]  prescale_select_r;
    logic        software_enable_r;
    logic [2:0]  clock_select_r;
    logic [2:0]  window_select_r;
    logic        armed_r;
    logic        sleep_r;
    logic        to_n_r;
    logic        pd_n_r;
    logic        cause_n_r;
    logic        wv_n_r;
    logic        wdt_reset_r;
    logic        wake_r;
    logic [7:0]  rdata_r;

    logic [wdt_pkg::COUNT_W-1:0] count;
    logic        core_timeout;
    logic [2:0]  eighth;

    logic        wr_ctrl0;
    logic        wr_ctrl1;
    logic        wr_status;
    logic        rd_ctrl0;
    logic        active;
    logic [4:0]  ps_eff;
    logic        tick;
    logic        windowed;
    logic        in_window;
    logic        violation;
    logic        valid_clear;
    logic        sleep_entry;
    logic        sleep_exit_clear;
    logic        cnt_clear;
    logic        timeout_ev;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign wr_ctrl0  = wr_in && (addr_in == wdt_pkg::OFF_CTRL0);
    assign wr_ctrl1  = wr_in && (addr_in == wdt_pkg::OFF_CTRL1);
    assign wr_status = wr_in && (addr_in == wdt_pkg::OFF_STATUS);
    assign rd_ctrl0  = rd_in && (addr_in == wdt_pkg::OFF_CTRL0);

    always_comb begin
        unique case (mode_field_in)
            wdt_pkg::MODE_ALWAYS: active = 1'b1;                  // R23
            wdt_pkg::MODE_AWAKE:  active = !sleep_in;             // R23
            wdt_pkg::MODE_SW:     active = software_enable_r;     // R15
            wdt_pkg::MODE_OFF:    active = 1'b0;                  // R23
        endcase
    end

    // reserved codes fall back to the shortest period
    assign ps_eff = (prescale_select_r > wdt_pkg::PS_MAX) ?
                    wdt_pkg::PS_MIN : prescale_select_r;          // R12

    // reserved clock codes use the low-frequency source rather than stopping
    // the watchdog; only the oscillator ticks advance it, never the core divider
    assign tick = (clock_select_r == wdt_pkg::CS_MF) ?
                  medium_freq_tick_in : low_freq_tick_in;         // R16 R10

    // ------------------------------------------------------------
    // window and clear
    // ------------------------------------------------------------
    assign windowed  = (window_select_r != wdt_pkg::WIN_FULL);
    assign in_window = (eighth >= ~window_select_r);              // R19

    assign violation   = clear_watchdog_in && active && windowed &&
                         (!armed_r || !in_window);                // R2 R27
    assign valid_clear = clear_watchdog_in && active && !violation; // R1

    assign sleep_entry      = sleep_in && !sleep_r;
    assign sleep_exit_clear = !sleep_in && sleep_r &&
                              ((mode_field_in != wdt_pkg::MODE_AWAKE) ||
                               listed_clock_in);                  // R9

    // counting resumes after the entry clear when active in sleep
    assign cnt_clear = load_pending_r || !active || osc_fail_in  // R8 R4
                    || ost_running_in                             // R5
                    || sleep_entry || sleep_exit_clear            // R3
                    || valid_clear || violation
                    || wr_ctrl0 || wr_ctrl1;                      // R25

    assign timeout_ev = core_timeout && active && !cnt_clear;

    wdt_count_core u_count (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .clear_in    (cnt_clear),
        .tick_in     (tick),
        .ps_code_in  (ps_eff),                                    // R11
        .count_out   (count),
        .timeout_out (core_timeout),
        .eighth_out  (eighth)
    );

    // ------------------------------------------------------------
    // configuration capture
    // ------------------------------------------------------------
    // async reset can only load constants, so straps are taken on the
    // first edge after release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            load_pending_r <= 1'b1;
        end else begin
            load_pending_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prescale_select_r <= wdt_pkg::PS_RST;
        end else if (load_pending_r) begin
            prescale_select_r <= (config_prescale_field_in == wdt_pkg::PS_UNLOCK) ?
                                 wdt_pkg::PS_DEFAULT : config_prescale_field_in; // R13
        end else if (wr_ctrl0 && config_prescale_field_in == wdt_pkg::PS_UNLOCK) begin
            prescale_select_r <= wdata_in[wdt_pkg::CTRL0_PS_LSB +: 5];  // R14
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            software_enable_r <= wdt_pkg::SEN_RST;
        end else if (wr_ctrl0) begin
            software_enable_r <= wdata_in[wdt_pkg::CTRL0_SEN_BIT];     // R15
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clock_select_r <= wdt_pkg::CS_RST;
        end else if (load_pending_r) begin
            clock_select_r <= (config_clock_select_field_in == wdt_pkg::CS_UNLOCK) ?
                              wdt_pkg::CS_DEFAULT : config_clock_select_field_in; // R17
        end else if (wr_ctrl1 && config_clock_select_field_in == wdt_pkg::CS_UNLOCK) begin
            clock_select_r <= wdata_in[wdt_pkg::CTRL1_CS_LSB +: 3];     // R18
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            window_select_r <= wdt_pkg::WIN_RST;
        end else if (load_pending_r) begin
            window_select_r <= config_window_field_in;                 // R20
        end else if (wr_ctrl1 && config_window_field_in == wdt_pkg::WIN_UNLOCK) begin
            window_select_r <= wdata_in[wdt_pkg::CTRL1_WIN_LSB +: 3];   // R21
        end
    end

    // ------------------------------------------------------------
    // arming and sleep tracking
    // ------------------------------------------------------------
    // a read in the same cycle as a counter clear leaves the watchdog armed
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            armed_r <= 1'b0;
        end else if (rd_ctrl0) begin
            armed_r <= 1'b1;                                           // R1 R27
        end else if (cnt_clear) begin
            armed_r <= 1'b0;                                           // R27
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sleep_r <= 1'b0;
        end else begin
            sleep_r <= sleep_in;
        end
    end

    // ------------------------------------------------------------
    // reset, wake and flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wdt_reset_r <= 1'b0;
            wake_r      <= 1'b0;
        end else begin
            wdt_reset_r <= (timeout_ev && !sleep_in) || violation;     // R26 R24
            wake_r      <= timeout_ev && sleep_in;                     // R6
        end
    end

    // hardware events win over a firmware restore in the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            to_n_r    <= wdt_pkg::FLAG_N_RST;
            pd_n_r    <= wdt_pkg::FLAG_N_RST;
            cause_n_r <= wdt_pkg::FLAG_N_RST;
        end else if (timeout_ev) begin
            to_n_r    <= 1'b0;                                         // R7
            cause_n_r <= 1'b0;                                         // R7
            if (sleep_in) begin
                pd_n_r <= 1'b0;                                        // R7
            end
        end else if (wr_status) begin
            to_n_r    <= to_n_r    | wdata_in[wdt_pkg::STAT_TO_BIT];
            pd_n_r    <= pd_n_r    | wdata_in[wdt_pkg::STAT_PD_BIT];
            cause_n_r <= cause_n_r | wdata_in[wdt_pkg::STAT_CAUSE_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wv_n_r <= wdt_pkg::FLAG_N_RST;
        end else if (violation) begin
            wv_n_r <= 1'b0;                                            // R24
        end else if (wr_status && wdata_in[wdt_pkg::STAT_WV_BIT]) begin
            wv_n_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_r <= wdt_pkg::RDATA_RST;
        end else if (!rd_in) begin
            rdata_r <= wdt_pkg::RDATA_RST;
        end else begin
            unique case (addr_in)
                wdt_pkg::OFF_CTRL0:  rdata_r <= {2'b00, prescale_select_r,
                                                software_enable_r};
                wdt_pkg::OFF_CTRL1:  rdata_r <= {1'b0, clock_select_r, 1'b0,
                                                window_select_r};
                wdt_pkg::OFF_PSL:    rdata_r <= count[7:0];            // R22
                wdt_pkg::OFF_PSH:    rdata_r <= count[15:8];           // R22
                wdt_pkg::OFF_TMR:    rdata_r <= {1'b0, count[21:18], armed_r,
                                                count[17:16]};         // R22
                wdt_pkg::OFF_STATUS: rdata_r <= {4'h0, wv_n_r, cause_n_r,
                                                pd_n_r, to_n_r};
                default:             rdata_r <= wdt_pkg::RDATA_RST;
            endcase
        end
    end

    assign rdata_out                       = rdata_r;
    assign wdt_reset_out                   = wdt_reset_r;
    assign wake_out                        = wake_r;
    assign armed_out                       = armed_r;
    assign timeout_flag_n_out              = to_n_r;
    assign power_down_flag_n_out           = pd_n_r;
    assign watchdog_reset_cause_flag_n_out = cause_n_r;
    assign window_violation_flag_n_out     = wv_n_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_arm_on_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
        rd_ctrl0 |=> armed_out ##0 (rdata_out[wdt_pkg::CTRL0_SEN_BIT] == $past(software_enable_r)))
        else $error("control zero read did not arm");

    chk_unarmed_violation: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R2
        (clear_watchdog_in && active && windowed && !armed_r)
        |=> (wdt_reset_out && !window_violation_flag_n_out))
        else $error("unarmed clear did not raise a violation");

    chk_sleep_entry_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
        (sleep_in && !sleep_r && !rd_ctrl0) |=> (count == '0) ##0 !armed_out)
        else $error("sleep entry did not clear the counter");

    chk_ost_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
        ost_running_in [*2] |-> (count == '0))
        else $error("counter moved while start-up timer runs");

    chk_sleep_wakes: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
        (timeout_ev && sleep_in) |=> (wake_out && !wdt_reset_out ##1
                                      !power_down_flag_n_out))
        else $error("sleep time-out did not wake cleanly");

    chk_disabled_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
        ((mode_field_in == wdt_pkg::MODE_OFF) || osc_fail_in ||
         (mode_field_in == wdt_pkg::MODE_SW && !software_enable_r)) |=> (count == '0))
        else $error("disabled watchdog counter not held clear");

    chk_ps_lock: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R14
        (wr_ctrl0 && !load_pending_r &&
         config_prescale_field_in != wdt_pkg::PS_UNLOCK) |=> $stable(prescale_select_r))
        else $error("locked prescale field changed");

    chk_ctrl_write_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R25
        (wr_ctrl0 || wr_ctrl1) |=> (count == '0))
        else $error("control write did not clear the counter");

    chk_awake_timeout: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R26
        (timeout_ev && !sleep_in) |=> wdt_reset_out ##1
                                      (!watchdog_reset_cause_flag_n_out && !timeout_flag_n_out))
        else $error("awake time-out did not reset the device");

endmodule : wdt_top

// File: verification/core_model.sv
`timescale 1ns/1ps

module core_model (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // request from bench
    input  wire logic go_in,
    // instruction stream
    output logic      clear_watchdog_out
);
    // a one-cycle request gives one pulse; a held request pulses every second cycle, one clear each
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clear_watchdog_out <= 1'b0;
        end else begin
            clear_watchdog_out <= go_in & ~clear_watchdog_out;
        end
    end
endmodule : core_model

// File: verification/windowed_watchdog_timer_test.sv
`timescale 1ns/1ps

module windowed_watchdog_timer_test;
    typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic       clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, go = 0, tick = 0;
    logic       sleep_in = 0, oscillator_startup_timer = 0, fail = 0, clr, rst_o, wake, to_n, pd_n, cs_n, wv_n;
    logic [3:0] addr_in = 4'h0;
    logic [4:0] cps = 5'h1F;
    logic [7:0] wdata_in = 8'h00, rdata_out, v;
    int         fail_count = 0, n_tests = 0, cyc = 0, hits = 0, n, h;
    int         codes [4] = '{0, 19, 31, 1};
    // config: all fields unlocked, software mode
    row_t       rows [7] = '{
        '{0, wdt_pkg::OFF_CTRL0, 8'h00, 8'h16}, '{0, wdt_pkg::OFF_CTRL1, 8'h00, 8'h07},
        '{0, 4'h6, 8'h00, 8'h00}, '{0, wdt_pkg::OFF_PSL, 8'h00, 8'h00},
        '{1, wdt_pkg::OFF_CTRL0, 8'hFF, 8'h3F}, '{1, wdt_pkg::OFF_CTRL1, 8'hFF, 8'h77},
        '{1, wdt_pkg::OFF_CTRL1, 8'h07, 8'h07}};

    always #4 clk_in = ~clk_in;

    core_model core_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go),
        .clear_watchdog_out(clr));
    wdt_top wdt_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .mode_field_in(2'h1), .config_prescale_field_in(cps),
        .config_clock_select_field_in(3'h7), .config_window_field_in(3'h7),
        .clear_watchdog_in(clr), .sleep_in(sleep_in), .low_freq_tick_in(tick),
        .medium_freq_tick_in(1'b0), .ost_running_in(oscillator_startup_timer), .osc_fail_in(fail),
        .listed_clock_in(1'b1), .wdt_reset_out(rst_o), .wake_out(wake), .armed_out(),
        .timeout_flag_n_out(to_n), .power_down_flag_n_out(pd_n),
        .watchdog_reset_cause_flag_n_out(cs_n), .window_violation_flag_n_out(wv_n));

    task automatic tally_and_finish();
        $display("mismatches %0d, checks %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 d = rdata_out;
    endtask : rd

    // an optional clear instruction, then count cycles to a reset or wake, bounded
    task automatic pulse_wait(input logic send, input int lim);
        if (send) begin
            @(posedge clk_in);
            go <= 1'b1;
            @(posedge clk_in);
            go <= 1'b0;
        end
        n = 0;
        #1;
        while (rst_o !== 1'b1 && wake !== 1'b1 && n < lim) begin
            @(posedge clk_in);
            #1 n++;
        end
    endtask : pulse_wait

    always @(posedge clk_in) begin
        cyc++;
        if (rst_o === 1'b1) hits++;
        if (cyc == 6000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            check(v, rows[i].e, "register");
        end
        @(posedge clk_in);
        tick <= 1'b1;
        foreach (codes[i]) begin
            wr(wdt_pkg::OFF_CTRL0, {2'b00, codes[i][4:0], 1'b1});
            pulse_wait(1'b0, 200);
            h = (codes[i] == 1) ? 64 : 32;
            check({7'h0, n >= h - 4 && n <= h + 4}, 8'h01, "period");
            check({6'h0, to_n, cs_n}, 8'h00, "timeout flags");
            wr(wdt_pkg::OFF_STATUS, 8'h0F);
        end
        wr(wdt_pkg::OFF_CTRL0, 8'h03);
        h = hits;
        repeat (4) pulse_wait(1'b1, 40);
        check(8'(hits - h) | {7'h0, rst_o}, 8'h00, "valid clears");
        wr(wdt_pkg::OFF_CTRL1, 8'h00);
        pulse_wait(1'b1, 6);
        check({6'h0, rst_o, wv_n}, 8'h02, "unarmed clear");
        wr(wdt_pkg::OFF_STATUS, 8'h0F);
        wr(wdt_pkg::OFF_CTRL1, 8'h00);
        rd(wdt_pkg::OFF_CTRL0, v);
        repeat (52) @(posedge clk_in);
        h = hits;
        pulse_wait(1'b1, 4);
        check(8'(hits - h) | {7'h0, rst_o}, 8'h00, "armed open clear");
        rd(wdt_pkg::OFF_CTRL0, v);
        pulse_wait(1'b1, 6);
        check({6'h0, rst_o, wv_n}, 8'h02, "closed clear");
        wr(wdt_pkg::OFF_STATUS, 8'h0F);
        wr(wdt_pkg::OFF_CTRL1, 8'h07);
        h = hits;
        sleep_in <= 1'b1;
        pulse_wait(1'b0, 200);
        check({4'(hits - h), wake, to_n, pd_n, cs_n}, 8'h08, "sleep wake");
        @(posedge clk_in);
        sleep_in <= 1'b0;
        oscillator_startup_timer <= 1'b1;
        repeat (10) @(posedge clk_in);
        rd(wdt_pkg::OFF_PSL, v);
        check(v, 8'h00, "start-up hold");
        @(posedge clk_in);
        oscillator_startup_timer  <= 1'b0;
        fail <= 1'b1;
        repeat (10) @(posedge clk_in);
        rd(wdt_pkg::OFF_PSL, v);
        check(v, 8'h00, "failure hold");
        // second power-on with a locked prescale strap
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        cps      <= 5'h02;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        rd(wdt_pkg::OFF_STATUS, v);
        check(v, 8'h0F, "flags after reset");
        rd(wdt_pkg::OFF_CTRL0, v);
        check(v, 8'h04, "strapped prescale");
        wr(wdt_pkg::OFF_CTRL0, 8'hFF);
        rd(wdt_pkg::OFF_CTRL0, v);
        check(v, 8'h05, "locked prescale");
        tally_and_finish();
    end
endmodule : windowed_watchdog_timer_test
